// ===== tlm_defines.vh
// constants for the travel-limit monitor: register map, field positions,
// reset values, error codes and timing figures
// assumes inclusion by bare name from the monitor, the checker and the bench
`ifndef TLM_DEFINES_VH
`define TLM_DEFINES_VH

// ==========================================================
// register byte offsets
`define TLM_OFF_CTRL     8'h00
`define TLM_OFF_POS_LIM  8'h04
`define TLM_OFF_NEG_LIM  8'h08
`define TLM_OFF_WIN      8'h0c
`define TLM_OFF_DEB      8'h10
`define TLM_OFF_TICKDIV  8'h14
`define TLM_OFF_STATUS   8'h18
`define TLM_OFF_ACK      8'h1c
`define TLM_OFF_ERRCODE  8'h20

// ==========================================================
// control register fields
`define TLM_CTRL_SW_EN     0
`define TLM_CTRL_MTURN     1
`define TLM_CTRL_SWAP      2
`define TLM_CTRL_INV_A     3
`define TLM_CTRL_INV_B     4
`define TLM_CTRL_INV_HOME  5
`define TLM_CTRL_REACT_LO  6
`define TLM_CTRL_REACT_HI  7
`define TLM_CTRL_HW_EN_A   8
`define TLM_CTRL_HW_EN_B   9
`define TLM_CTRL_DEB_IN0   10
`define TLM_CTRL_W         11
`define TLM_CTRL_RST       11'h380

// ==========================================================
// hardware-limit reaction codes
`define TLM_REACT_NONE     2'h0
`define TLM_REACT_STOP     2'h1
`define TLM_REACT_DEENERG  2'h2

// ==========================================================
// error codes reported to the error handler
`define TLM_ERR_NONE       16'h0000
`define TLM_ERR_SW_POS     16'h7323
`define TLM_ERR_SW_NEG     16'h7324
`define TLM_ERR_HW_A       16'h54a0
`define TLM_ERR_HW_B       16'h54a1

// ==========================================================
// command modes
`define TLM_MODE_JOG       2'h0
`define TLM_MODE_MOVE      2'h1
`define TLM_MODE_GEAR      2'h2
`define TLM_MODE_VEL       2'h3

// ==========================================================
// timing: sample period in ns, clock period in ns, debounce range in ms
`define TLM_SAMPLE_NS      500000
`define TLM_CLK_NS         10
`define TLM_TICK_CYCLES    (`TLM_SAMPLE_NS / `TLM_CLK_NS)
`define TLM_DEB_MAX_MS     20
`define TLM_SAMPLES_PER_MS 2
`define TLM_HIST_W         (`TLM_DEB_MAX_MS * `TLM_SAMPLES_PER_MS)

`endif

// ===== tlm_travel_limit_monitor.v
// travel-limit supervision for one servo axis: software end limits with
// hysteresis and direction block, hardware limit switches, debouncer
// assumes an apb master on pclk and synchronous switch and motion inputs
//
// Function
// - flag limit error using setpoint or actual
// - de-energized: rearm only beyond window distance
// - codes 0x7323 positive, 0x7324 negative
// - inactive until reference run completes
// - no monitoring during homing run
// - multi-turn feedback enforces limits at once
// - limits disabled: every command allowed
// - acknowledge, then block allows inward moves
// - block refuses outward moves with error
// - jog clamps, refuses outward, allows inward
// - positioning moves beyond limit refused, error
// - gearing clamps with error, outside refused
// - velocity clamps with error, inward allowed
// - hardware reaction none, stop, de-energize
// - enabled switch: ramp, de-energize, 0x54a0/0x54a1
// - homing reversal switches raise no error
// - ack with switch active, only inward while swap is off
// - sample switches and input 0 every 0.5ms
// - majority of samples toggles filtered state
// - debounce 0 to 20ms, zero bypasses
// - swap exchanges negative and positive switch (here swap only turns off the inward-only check, codes stay on a and b)
// - low-active options, default high-active
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "tlm_defines.vh"

module tlm_travel_limit_monitor #(
  parameter TICK_CYCLES = `TLM_TICK_CYCLES
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // switch inputs
  input  wire        switch_input_a,
  input  wire        switch_input_b,
  input  wire        home_input,
  input  wire        general_input_zero,
  // axis state
  input  wire        energized,
  input  wire        homing_active,
  input  wire        homing_reversal,
  input  wire        homing_done,
  input  wire [31:0] setpoint_pos,
  input  wire [31:0] actual_pos,
  // motion command from setpoint generator
  input  wire        cmd_valid,
  input  wire [1:0]  cmd_mode,
  input  wire [31:0] cmd_target,
  output reg         cmd_accept,
  output reg         cmd_clamp,
  output reg         cmd_refuse,
  // error handler
  output reg         limit_error,
  output reg  [15:0] error_code,
  output reg         ramp_stop,
  output reg         de_energize,
  // filtered inputs
  output reg         home_filtered,
  output reg         input_zero_filtered
);

  // ==========================================================
  // registers
  reg [`TLM_CTRL_W-1:0] ctrl_r;
  reg signed [31:0]     pos_lim_r;
  reg signed [31:0]     neg_lim_r;
  reg [31:0]            win_r;
  reg [4:0]             deb_ms_r;
  reg [31:0]            tick_div_r;
  reg [31:0]            tick_cnt_r;
  reg                   tick_r;
  reg                   referenced_r;
  reg                   pos_armed_r;
  reg                   neg_armed_r;
  reg                   blk_pos_r;
  reg                   blk_neg_r;
  reg                   sw_err_r;
  reg                   hw_prev_a_r;
  reg                   hw_prev_b_r;
  reg [3:0]             filt_r;
  wire [3:0]            raw;
  wire [5:0]            n_samp;
  wire                  wr_en;
  wire                  rd_setup;
  wire                  ack;

  // ==========================================================
  // apb decode
  assign wr_en    = psel & penable & pwrite & pready;
  assign rd_setup = psel & ~penable;
  assign ack      = wr_en & (paddr == `TLM_OFF_ACK) & pwdata[0];

  // register writes, ack is a write-only strobe
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r     <= `TLM_CTRL_RST;
      pos_lim_r  <= 32'h7fffffff;
      neg_lim_r  <= 32'h80000000;
      win_r      <= 32'h0000000a;
      deb_ms_r   <= 5'h00;
      tick_div_r <= TICK_CYCLES;
    end
    else if (wr_en)
    begin
      case (paddr)
        `TLM_OFF_CTRL:    ctrl_r    <= pwdata[`TLM_CTRL_W-1:0];
        `TLM_OFF_POS_LIM: pos_lim_r <= pwdata;
        `TLM_OFF_NEG_LIM: neg_lim_r <= pwdata;
        `TLM_OFF_WIN:     win_r     <= pwdata;
        // clamp to the allowed debounce range
        `TLM_OFF_DEB:     deb_ms_r  <= (pwdata > `TLM_DEB_MAX_MS) ?
                                       5'd20 : pwdata[4:0];
        `TLM_OFF_TICKDIV: tick_div_r <= (pwdata == 32'h0) ? 32'h1 : pwdata;
        default:          ;
      endcase
    end
  end

  // read data and error answer captured in setup, zero wait states
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (rd_setup)
      begin
        pslverr <= 1'b0;
        case (paddr)
          `TLM_OFF_CTRL:    prdata <= {21'h0, ctrl_r};
          `TLM_OFF_POS_LIM: prdata <= pos_lim_r;
          `TLM_OFF_NEG_LIM: prdata <= neg_lim_r;
          `TLM_OFF_WIN:     prdata <= win_r;
          `TLM_OFF_DEB:     prdata <= {27'h0, deb_ms_r};
          `TLM_OFF_TICKDIV: prdata <= tick_div_r;
          `TLM_OFF_STATUS:  prdata <= {20'h0, filt_r, blk_neg_r, blk_pos_r,
                                       referenced_r, sw_err_r, ramp_stop,
                                       de_energize, limit_error, energized};
          `TLM_OFF_ACK:     prdata <= 32'h0;
          `TLM_OFF_ERRCODE: prdata <= {16'h0, error_code};
          default:
          begin
            prdata  <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // sample tick from programmable divider
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
    end
    else if (tick_cnt_r + 32'h1 >= tick_div_r)
    begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      tick_r     <= 1'b0;
    end
  end

  // ==========================================================
  // polarity, then majority debounce per input
  assign raw[0] = switch_input_a ^ ctrl_r[`TLM_CTRL_INV_A];
  assign raw[1] = switch_input_b ^ ctrl_r[`TLM_CTRL_INV_B];
  assign raw[2] = home_input     ^ ctrl_r[`TLM_CTRL_INV_HOME];
  assign raw[3] = general_input_zero;
  assign n_samp = {deb_ms_r, 1'b0}; // two samples per millisecond

  // count of ones among the newest n samples
  function [5:0] tlm_ones;
    input [`TLM_HIST_W-1:0] hist;
    input [5:0]             n;
    integer                 i;
    begin
      tlm_ones = 6'h0;
      for (i = 0; i < `TLM_HIST_W; i = i + 1)
        if (i < n && hist[i])
          tlm_ones = tlm_ones + 6'h1;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : deb
      reg  [`TLM_HIST_W-1:0] hist_r;
      wire [5:0]             ones;
      wire                   bypass;
      assign ones   = tlm_ones(hist_r, n_samp);
      assign bypass = (n_samp == 6'h0) ||
                      (g == 3 && !ctrl_r[`TLM_CTRL_DEB_IN0]);
      // history shift and majority decision
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          hist_r   <= {`TLM_HIST_W{1'b0}};
          filt_r[g] <= 1'b0;
        end
        else if (bypass)
          filt_r[g] <= raw[g];
        else if (tick_r)
        begin
          hist_r <= {hist_r[`TLM_HIST_W-2:0], raw[g]};
          if (!filt_r[g] && ({ones, 1'b0} > n_samp))
            filt_r[g] <= 1'b1;
          else if (filt_r[g] && ({n_samp - ones, 1'b0} > n_samp))
            filt_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // side assignment and limit evaluation
  wire               swap    = ctrl_r[`TLM_CTRL_SWAP];
  wire               sw_neg  = swap ? filt_r[1] : filt_r[0];
  wire               sw_pos  = swap ? filt_r[0] : filt_r[1];
  wire signed [31:0] mon_pos = energized ? setpoint_pos : actual_pos;
  wire signed [31:0] tgt     = cmd_target;
  wire               sw_en   = ctrl_r[`TLM_CTRL_SW_EN];
  wire               active  = sw_en & ~homing_active &
                               (referenced_r | ctrl_r[`TLM_CTRL_MTURN]);
  wire               out_pos = mon_pos > pos_lim_r;
  wire               out_neg = mon_pos < neg_lim_r;
  wire               tgt_pos = tgt > pos_lim_r;
  wire               tgt_neg = tgt < neg_lim_r;
  wire               inward  = (out_pos & (tgt < mon_pos)) | (out_neg & (tgt > mon_pos));
  wire               outside = out_pos | out_neg;
  wire               away    = (out_pos & (tgt > mon_pos)) | (out_neg & (tgt < mon_pos)) |
                               (blk_pos_r & (tgt > mon_pos)) | (blk_neg_r & (tgt < mon_pos));
  wire               far_pos = (mon_pos + $signed(win_r)) < pos_lim_r;
  wire               far_neg = (mon_pos - $signed(win_r)) > neg_lim_r;
  wire               hw_en_a = ctrl_r[`TLM_CTRL_HW_EN_A];
  wire               hw_en_b = ctrl_r[`TLM_CTRL_HW_EN_B];
  wire [1:0]         react   = ctrl_r[`TLM_CTRL_REACT_HI:`TLM_CTRL_REACT_LO];
  wire               hw_ok   = ~homing_active | ~homing_reversal;
  wire               hw_a    = hw_en_a & filt_r[0] & hw_ok;
  wire               hw_b    = hw_en_b & filt_r[1] & hw_ok;
  wire               hw_rise_a = hw_a & ~hw_prev_a_r & (react != `TLM_REACT_NONE);
  wire               hw_rise_b = hw_b & ~hw_prev_b_r & (react != `TLM_REACT_NONE);
  wire               hw_into = (sw_pos & hw_ok & (tgt > mon_pos)) |
                               (sw_neg & hw_ok & (tgt < mon_pos));

  // command verdict, one of accept, clamp or refuse, plus error
  reg        v_acc;
  reg        v_clamp;
  reg        v_ref;
  reg        v_err;
  always @*
  begin
    v_acc   = 1'b1;
    v_clamp = 1'b0;
    v_ref   = 1'b0;
    v_err   = 1'b0;
    if (!active)
      v_acc = 1'b1;
    else if (away)
    begin
      v_acc = 1'b0;
      v_ref = 1'b1;
      v_err = (cmd_mode != `TLM_MODE_JOG) | blk_pos_r | blk_neg_r;
    end
    else if (outside)
    begin
      // heading back into the range
      v_acc = (cmd_mode != `TLM_MODE_GEAR) & inward;
      v_ref = ~v_acc;
      v_err = ~v_acc;
    end
    else if (tgt_pos | tgt_neg)
    begin
      case (cmd_mode)
        `TLM_MODE_JOG:
          v_clamp = 1'b1;
        `TLM_MODE_MOVE:
        begin
          v_acc = 1'b0;
          v_ref = 1'b1;
          v_err = 1'b1;
        end
        default:
        begin
          v_clamp = 1'b1;
          v_err   = 1'b1;
        end
      endcase
      v_acc = v_acc & ~v_clamp;
    end
    // fixed assignment: no travel deeper into an active switch
    if (!swap && hw_into)
    begin
      v_acc   = 1'b0;
      v_clamp = 1'b0;
      v_ref   = 1'b1;
    end
  end

  // software limit crossing events
  wire ev_pos = active & pos_armed_r & out_pos;
  wire ev_neg = active & neg_armed_r & out_neg;
  wire ev_cmd = cmd_valid & v_err;
  wire cmd_side_pos = out_pos | tgt_pos | blk_pos_r | (tgt > mon_pos);

  // ==========================================================
  // error, block and arming state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      referenced_r <= 1'b0;
      pos_armed_r  <= 1'b1;
      neg_armed_r  <= 1'b1;
      blk_pos_r    <= 1'b0;
      blk_neg_r    <= 1'b0;
      sw_err_r     <= 1'b0;
      hw_prev_a_r  <= 1'b0;
      hw_prev_b_r  <= 1'b0;
      limit_error  <= 1'b0;
      error_code   <= `TLM_ERR_NONE;
      ramp_stop    <= 1'b0;
      de_energize  <= 1'b0;
    end
    else
    begin
      hw_prev_a_r <= hw_a;
      hw_prev_b_r <= hw_b;
      if (homing_done)
        referenced_r <= 1'b1;
      // rearm back inside when energized, else clear of the band
      if (ev_pos)
        pos_armed_r <= 1'b0;
      else if ((energized & ~out_pos) | far_pos)
        pos_armed_r <= 1'b1;
      if (ev_neg)
        neg_armed_r <= 1'b0;
      else if ((energized & ~out_neg) | far_neg)
        neg_armed_r <= 1'b1;
      // acknowledged software error arms the direction block
      if (ack && sw_err_r)
      begin
        blk_pos_r <= out_pos;
        blk_neg_r <= out_neg;
      end
      else
      begin
        if (!out_pos)
          blk_pos_r <= 1'b0;
        if (!out_neg)
          blk_neg_r <= 1'b0;
      end
      // new events win over the clear by acknowledge
      if (ev_pos | ev_neg | ev_cmd)
      begin
        limit_error <= 1'b1;
        sw_err_r    <= 1'b1;
        error_code  <= (ev_pos | (~ev_neg & cmd_side_pos)) ?
                       `TLM_ERR_SW_POS : `TLM_ERR_SW_NEG;
      end
      else if (hw_rise_a | hw_rise_b)
      begin
        limit_error <= 1'b1;
        sw_err_r    <= 1'b0;
        error_code  <= hw_rise_a ? `TLM_ERR_HW_A : `TLM_ERR_HW_B;
        ramp_stop   <= 1'b1;
        de_energize <= (react == `TLM_REACT_DEENERG);
      end
      else if (ack)
      begin
        // accepted even while the switch is still active
        limit_error <= 1'b0;
        sw_err_r    <= 1'b0;
        error_code  <= `TLM_ERR_NONE;
        ramp_stop   <= 1'b0;
        de_energize <= 1'b0;
      end
    end
  end

  // ==========================================================
  // registered command answer and filtered outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_accept          <= 1'b0;
      cmd_clamp           <= 1'b0;
      cmd_refuse          <= 1'b0;
      home_filtered       <= 1'b0;
      input_zero_filtered <= 1'b0;
    end
    else
    begin
      cmd_accept          <= cmd_valid & v_acc;
      cmd_clamp           <= cmd_valid & v_clamp;
      cmd_refuse          <= cmd_valid & v_ref;
      home_filtered       <= filt_r[2];
      input_zero_filtered <= filt_r[3];
    end
  end

endmodule // tlm_travel_limit_monitor

// ===== tlm_monitor_sva.sv
// checker on the monitor ports: verdicts, error codes, hardware reaction
// assumes binding to tlm_travel_limit_monitor on the single pclk domain
`timescale 1ns/10ps
`include "tlm_defines.vh"
module tlm_monitor_sva (
  // clock and apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  // axis and command
  input wire logic        homing_active,
  input wire logic        homing_reversal,
  input wire logic        cmd_valid,
  input wire logic [1:0]  cmd_mode,
  input wire logic        cmd_accept,
  input wire logic        cmd_clamp,
  input wire logic        cmd_refuse,
  // error handler
  input wire logic        limit_error,
  input wire logic [15:0] error_code,
  input wire logic        ramp_stop,
  input wire logic        de_energize
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // acknowledge write completing on the bus
  wire ack_wr = psel && penable && pready && pwrite && paddr == `TLM_OFF_ACK;
  // ==========================================================
  // command and reaction steps
  sequence s_req;
    cmd_valid;
  endsequence
  sequence s_hw_rise;
    $rose(ramp_stop);
  endsequence
  sequence s_sw_rise;
    $rose(limit_error) && error_code[15:8] == 8'h73;
  endsequence
  // ==========================================================
  // assertions
  a_one_verdict: assert property (s_req |=> $onehot({cmd_accept, cmd_clamp, cmd_refuse}))
    else $error("not exactly one verdict");
  a_idle_quiet: assert property (!cmd_valid |=> !(cmd_accept || cmd_clamp || cmd_refuse))
    else $error("verdict without request");
  a_code_legal: assert property (limit_error |-> error_code inside {16'h7323, 16'h7324,
    16'h54a0, 16'h54a1}) else $error("illegal error code");
  a_stop_first: assert property (de_energize |-> ramp_stop)
    else $error("de-energize without ramp");
  a_hw_error: assert property (s_hw_rise |-> limit_error)
    else $error("ramp without error");
  a_rev_quiet: assert property (s_hw_rise |-> !$past(homing_reversal))
    else $error("reversal switch raised error");
  a_homing_quiet: assert property (s_sw_rise |-> !$past(homing_active))
    else $error("end limit error during homing");
  a_err_sticky: assert property (limit_error && !ack_wr |=> limit_error)
    else $error("error dropped without ack");
  a_move_noclamp: assert property (cmd_clamp |-> $past(cmd_mode) != `TLM_MODE_MOVE)
    else $error("positioning move clamped");
  a_clamp_err: assert property (cmd_clamp && $past(cmd_mode[1]) |-> limit_error)
    else $error("gear or velocity clamp without error");
endmodule // tlm_monitor_sva

bind tlm_travel_limit_monitor tlm_monitor_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pready, .homing_active, .homing_reversal, .cmd_valid, .cmd_mode, .cmd_accept,
  .cmd_clamp, .cmd_refuse, .limit_error, .error_code, .ramp_stop, .de_energize);

// ===== tlm_axis_model.sv
// axis model: limit and home switches, axis state, setpoint generator
// assumes the bench sets its levels and calls issue right after an edge
`timescale 1ns/10ps
module tlm_axis_model (
  // clock and command answer
  input  wire logic  pclk,
  input  wire logic  cmd_accept,
  input  wire logic  cmd_clamp,
  input  wire logic  cmd_refuse,
  // switches
  output logic        switch_input_a = 1'b0,
  output logic        switch_input_b = 1'b0,
  output logic        home_input = 1'b0,
  output logic        general_input_zero = 1'b0,
  // axis state
  output logic        energized = 1'b1,
  output logic        homing_active = 1'b0,
  output logic        homing_reversal = 1'b0,
  output logic        homing_done = 1'b0,
  output logic [31:0] setpoint_pos = 32'h0,
  output logic [31:0] actual_pos = 32'h0,
  // command request
  output logic        cmd_valid = 1'b0,
  output logic [1:0]  cmd_mode = 2'h0,
  output logic [31:0] cmd_target = 32'h0
);
  // one request pulse, verdict taken in the cycle after
  task automatic issue(input logic [1:0] md, input logic [31:0] t, output logic [2:0] v);
    cmd_mode <= md;
    cmd_target <= t;
    cmd_valid <= 1'b1;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    #1 v = {cmd_accept, cmd_clamp, cmd_refuse};
    @(posedge pclk);
  endtask
endmodule // tlm_axis_model

// ===== tlm_travel_limit_monitor_tb_top.sv
// bench for the travel-limit monitor: apb tasks, directed command tests
// assumes the axis model drives all axis inputs and the checker is bound
`timescale 1ns/10ps
`include "tlm_defines.vh"
module tlm_travel_limit_monitor_tb_top;
  localparam logic [2:0] ACC = 3'h4;
  localparam logic [2:0] CLP = 3'h2;
  localparam logic [2:0] REF = 3'h1;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, slverr;
  wire         switch_input_a, switch_input_b, home_input, general_input_zero, energized;
  wire         homing_active, homing_reversal, homing_done, cmd_valid;
  wire         cmd_accept, cmd_clamp, cmd_refuse, limit_error, ramp_stop, de_energize;
  wire         home_filtered, input_zero_filtered;
  wire  [1:0]  cmd_mode;
  wire  [15:0] error_code;
  wire  [31:0] setpoint_pos, actual_pos, cmd_target;
  int          n_errors = 0;
  int          check_count = 0;
  // design, axis model
  tlm_travel_limit_monitor #(.TICK_CYCLES(8)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .switch_input_a, .switch_input_b, .home_input,
    .general_input_zero, .energized, .homing_active, .homing_reversal, .homing_done,
    .setpoint_pos, .actual_pos, .cmd_valid, .cmd_mode, .cmd_target, .cmd_accept, .cmd_clamp,
    .cmd_refuse, .limit_error, .error_code, .ramp_stop, .de_energize, .home_filtered,
    .input_zero_filtered);
  tlm_axis_model m (.pclk, .cmd_accept, .cmd_clamp, .cmd_refuse, .switch_input_a,
    .switch_input_b, .home_input, .general_input_zero, .energized, .homing_active,
    .homing_reversal, .homing_done, .setpoint_pos, .actual_pos, .cmd_valid, .cmd_mode,
    .cmd_target);
  // 100 mhz clock
  always #5 pclk = ~pclk;
  // ==========================================================
  // tasks
  task automatic wait_clk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rdat, e);
  endtask
  task automatic ack();
    wr(`TLM_OFF_ACK, 32'h1);
    wait_clk(2);
  endtask
  task automatic lim(input logic [15:0] ec);
    chk("limit_error", {31'h0, limit_error}, {31'h0, ec != 16'h0});
    chk("error_code", {16'h0, error_code}, {16'h0, ec});
  endtask
  // request, verdict, error, then acknowledge when an error code is expected
  task automatic cmd(input logic [1:0] md, input logic [31:0] t, input logic [2:0] ev,
                     input logic [15:0] ec);
    logic [2:0] v;
    m.issue(md, t, v);
    chk("verdict", {29'h0, v}, {29'h0, ev});
    lim(ec);
    if (ec != 16'h0)
      ack();
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    wait_clk(2);
    presetn <= 1'b1;
    wait_clk(2);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // watchdog
  initial
  begin
    #300000;
    n_errors++;
    conclude();
  end
  // ==========================================================
  // tests
  initial
  begin
    do_reset();
    rd(`TLM_OFF_CTRL, 32'h380);
    rd(`TLM_OFF_POS_LIM, 32'h7fffffff);
    rd(`TLM_OFF_NEG_LIM, 32'h80000000);
    rd(`TLM_OFF_WIN, 32'ha);
    rd(`TLM_OFF_DEB, 32'h0);
    rd(`TLM_OFF_TICKDIV, 32'h8);
    rd(8'h24, 32'h0);
    chk("pslverr", {31'h0, slverr}, 32'h1);
    $display("end of register test");
    // software limits, homing, direction block
    wr(`TLM_OFF_POS_LIM, 32'd1000);
    wr(`TLM_OFF_NEG_LIM, 32'hfffffc18);
    wr(`TLM_OFF_CTRL, 32'h381);
    m.setpoint_pos <= 32'd2000;
    wait_clk(4);
    lim(16'h0);
    m.homing_active <= 1'b1;
    m.homing_done <= 1'b1;
    wait_clk(1);
    m.homing_done <= 1'b0;
    wait_clk(4);
    lim(16'h0);
    m.homing_active <= 1'b0;
    wait_clk(4);
    lim(`TLM_ERR_SW_POS);
    m.setpoint_pos <= 32'd0;
    m.actual_pos <= 32'd2000;
    m.energized <= 1'b0;
    wait_clk(4);
    ack();
    m.actual_pos <= 32'd2003;
    wait_clk(4);
    lim(16'h0);
    cmd(`TLM_MODE_MOVE, 32'd3000, REF, `TLM_ERR_SW_POS);
    cmd(`TLM_MODE_GEAR, 32'd0, REF, `TLM_ERR_SW_POS);
    cmd(`TLM_MODE_MOVE, 32'd0, ACC, 16'h0);
    cmd(`TLM_MODE_VEL, 32'd0, ACC, 16'h0);
    m.actual_pos <= 32'd985;
    wait_clk(4);
    m.actual_pos <= 32'd1001;
    wait_clk(4);
    lim(`TLM_ERR_SW_POS);
    ack();
    m.actual_pos <= 32'd0;
    wait_clk(4);
    $display("end of end limit test");
    // verdicts from inside the range
    cmd(`TLM_MODE_MOVE, 32'd500, ACC, 16'h0);
    cmd(`TLM_MODE_JOG, 32'd3000, CLP, 16'h0);
    cmd(`TLM_MODE_MOVE, 32'd3000, REF, `TLM_ERR_SW_POS);
    cmd(`TLM_MODE_GEAR, 32'd3000, CLP, `TLM_ERR_SW_POS);
    cmd(`TLM_MODE_VEL, 32'hfffff448, CLP, `TLM_ERR_SW_NEG);
    cmd(`TLM_MODE_MOVE, 32'hfffff448, REF, `TLM_ERR_SW_NEG);
    wr(`TLM_OFF_CTRL, 32'h380);
    cmd(`TLM_MODE_MOVE, 32'd5000, ACC, 16'h0);
    $display("end of mode test");
    // hardware limit switches
    wr(`TLM_OFF_TICKDIV, 32'h4);
    wr(`TLM_OFF_CTRL, 32'h381);
    m.switch_input_a <= 1'b1;
    wait_clk(4);
    lim(`TLM_ERR_HW_A);
    chk("stop", {ramp_stop, de_energize}, 32'h3);
    ack();
    lim(16'h0);
    cmd(`TLM_MODE_MOVE, 32'hfffffe0c, REF, 16'h0);
    cmd(`TLM_MODE_MOVE, 32'd500, ACC, 16'h0);
    m.switch_input_a <= 1'b0;
    wr(`TLM_OFF_CTRL, 32'h341);
    m.switch_input_b <= 1'b1;
    wait_clk(4);
    lim(`TLM_ERR_HW_B);
    chk("stop", {ramp_stop, de_energize}, 32'h2);
    ack();
    m.switch_input_b <= 1'b0;
    wr(`TLM_OFF_CTRL, 32'h301);
    m.switch_input_a <= 1'b1;
    wait_clk(4);
    lim(16'h0);
    m.switch_input_a <= 1'b0;
    wr(`TLM_OFF_CTRL, 32'h389);
    wait_clk(4);
    lim(`TLM_ERR_HW_A);
    ack();
    wr(`TLM_OFF_CTRL, 32'h381);
    m.homing_active <= 1'b1;
    m.homing_reversal <= 1'b1;
    m.switch_input_b <= 1'b1;
    wait_clk(4);
    lim(16'h0);
    m.switch_input_b <= 1'b0;
    wait_clk(4);
    m.homing_active <= 1'b0;
    m.homing_reversal <= 1'b0;
    $display("end of switch test");
    // debouncer
    m.home_input <= 1'b1;
    wait_clk(3);
    chk("home", {31'h0, home_filtered}, 32'h1);
    m.home_input <= 1'b0;
    wr(`TLM_OFF_DEB, 32'd25);
    rd(`TLM_OFF_DEB, 32'd20);
    wr(`TLM_OFF_DEB, 32'd1);
    wr(`TLM_OFF_CTRL, 32'h781);
    m.home_input <= 1'b1;
    m.general_input_zero <= 1'b1;
    wait_clk(3);
    m.home_input <= 1'b0;
    m.general_input_zero <= 1'b0;
    wait_clk(20);
    chk("glitch", {home_filtered, input_zero_filtered}, 32'h0);
    m.home_input <= 1'b1;
    m.general_input_zero <= 1'b1;
    wait_clk(24);
    chk("steady", {home_filtered, input_zero_filtered}, 32'h3);
    $display("end of debounce test");
    // multi-turn feedback after a fresh reset
    m.energized <= 1'b1;
    do_reset();
    wr(`TLM_OFF_POS_LIM, 32'd1000);
    wr(`TLM_OFF_CTRL, 32'h383);
    m.setpoint_pos <= 32'd2000;
    wait_clk(4);
    lim(`TLM_ERR_SW_POS);
    $display("end of multi-turn test");
    conclude();
  end
endmodule // tlm_travel_limit_monitor_tb_top
